// >>> inc/pwpg_map.vh
`ifndef PWPG_MAP_VH
`define PWPG_MAP_VH

// Register offsets (byte addresses on the local register port)
`define PWPG_G1_CLR_OFS 8'h00
`define PWPG_G1_SET_OFS 8'h04
`define PWPG_G2_CLR_OFS 8'h10
`define PWPG_ERR_STAT_OFS 8'h20
`define PWPG_ERR_INFO_OFS 8'h24
`define PWPG_ERR_CNT_OFS 8'h28

// Reset values
`define PWPG_G1_RESET 32'h00000002
`define PWPG_G2_RESET 32'h00800000
`define PWPG_ERR_RESET 32'h00000000

// Implemented guard bits of each group
`define PWPG_G1_MASK 32'h0000000e
`define PWPG_G2_MASK 32'h000ffffe

// Group one field positions
`define PWPG_G1_PORT_BIT 3
`define PWPG_G1_NVM_BIT 2
`define PWPG_G1_DBG_BIT 1

// Group two field positions
`define PWPG_G2_TOUCH_BIT 19
`define PWPG_G2_DAC_BIT 18
`define PWPG_G2_CMP_BIT 17
`define PWPG_G2_ADC_BIT 16
`define PWPG_G2_TIMER_LSB 8
`define PWPG_G2_TIMER_MSB 15
`define PWPG_G2_SERIAL_LSB 2
`define PWPG_G2_SERIAL_MSB 7
`define PWPG_G2_EVENT_BIT 1

// Error status bits
`define PWPG_ERR_REPEAT_BIT 0
`define PWPG_ERR_LOCKED_BIT 1
`define PWPG_ERR_UNMAP_BIT 2

// Error info fields
`define PWPG_INFO_IDX_LSB 0
`define PWPG_INFO_ADDR_LSB 8
`define PWPG_INFO_SRC_BIT 16

`endif

// >>> testbench/pwpg_cpu_model.sv
`timescale 1ns/10ps
module pwpg_cpu_model (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // Attempt request from the bench
    input wire req_i,
    input wire [5:0] idx_i,
    // Write attempt towards the guard
    output reg wr_o,
    output reg [5:0] idx_o
);
    // Idle index keeps moving so a stale target can never pass for a real one
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_o <= 1'b0;
            idx_o <= 6'h00;
        end else begin
            wr_o <= req_i;
            idx_o <= req_i ? idx_i : ~idx_o;
        end
    end
endmodule

// >>> testbench/pwpg_top_sva.sv
`timescale 1ns/10ps
module pwpg_top_sva #(
    parameter CNT_W = 16
) (
    input wire CLK_SYS_I,
    input wire ARST_N_I,
    input wire [7:0] REG_ADDR_I,
    input wire [31:0] REG_WDATA_I,
    input wire [3:0] REG_BE_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [31:0] REG_RDATA_O,
    input wire REG_ERR_O,
    input wire PERIPH_WR_I,
    input wire [5:0] PERIPH_IDX_I,
    input wire PERIPH_GRANT_O,
    input wire PERIPH_ERR_O,
    input wire [31:0] GRP1_LOCK_O,
    input wire [31:0] GRP2_LOCK_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);
    wire lk = PERIPH_IDX_I[5] ? GRP2_LOCK_O[PERIPH_IDX_I[4:0]] : GRP1_LOCK_O[PERIPH_IDX_I[4:0]];
    wire w1 = REG_WR_I && REG_BE_I[0] && REG_ADDR_I[7:2] == 6'h01;
    wire w0 = REG_WR_I && REG_BE_I[0] && REG_ADDR_I[7:2] == 6'h00;
    chk_grant_lock: assert property (PERIPH_GRANT_O == (PERIPH_WR_I && !lk))
        else $error("grant disagrees with lock");
    chk_perr_pulse: assert property (PERIPH_WR_I && lk |=> PERIPH_ERR_O)
        else $error("locked write not flagged");
    chk_g1_bits: assert property ((GRP1_LOCK_O & ~32'h0000000e) == 32'h0)
        else $error("group one stray bit");
    chk_g2_bits: assert property ((GRP2_LOCK_O & ~32'h000ffffe) == 32'h0)
        else $error("group two stray bit");
    chk_rd_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
        else $error("read data outside its cycle");
    chk_set_lock: assert property (w1 |=>
        GRP1_LOCK_O[3:1] == ($past(GRP1_LOCK_O[3:1]) | $past(REG_WDATA_I[3:1])))
        else $error("set write wrong");
    chk_clr_unlock: assert property (w0 |=>
        GRP1_LOCK_O[3:1] == ($past(GRP1_LOCK_O[3:1]) & ~$past(REG_WDATA_I[3:1])))
        else $error("clear write wrong");
    chk_repeat_err: assert property (w1 && (REG_WDATA_I[3:1] & GRP1_LOCK_O[3:1]) != 3'h0 |=> REG_ERR_O)
        else $error("repeat lock not flagged");
    chk_unlock_err: assert property (w0 && (REG_WDATA_I[3:1] & ~GRP1_LOCK_O[3:1]) != 3'h0 |=> REG_ERR_O)
        else $error("repeat unlock not flagged");
    cov_refused: cover property (PERIPH_WR_I && lk);
    cov_repeat: cover property (REG_ERR_O);
    cov_set: cover property (w1);
endmodule

// >>> testbench/test_pwpg_top.sv
`timescale 1ns/10ps
module test_pwpg_top;
    reg clk, arst_n, wr, rd, req;
    reg [7:0] addr;
    reg [31:0] wdata;
    reg [3:0] be;
    reg [5:0] pidx;
    wire [31:0] rdata, g1, g2;
    wire err, pwr, grant, perr;
    wire [5:0] idx;
    integer errors = 0;
    integer total_checks = 0;
    pwpg_cpu_model cpu_u (.clk_i(clk), .arst_n_i(arst_n), .req_i(req), .idx_i(pidx), .wr_o(pwr), .idx_o(idx));
    pwpg_top #(.CNT_W(16)) dut_u (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_BE_I(be), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_ERR_O(err), .PERIPH_WR_I(pwr),
        .PERIPH_IDX_I(idx), .PERIPH_GRANT_O(grant), .PERIPH_ERR_O(perr), .GRP1_LOCK_O(g1), .GRP2_LOCK_O(g2));
    task test_done;
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wrr(input [7:0] a, input [31:0] d, input [3:0] b, input e);
        @(posedge clk);
        {wr, addr, wdata, be} <= {1'b1, a, d, b};
        @(posedge clk);
        wr <= 1'b0;
        #1 chk(err, e);
    endtask
    task rdr(input [7:0] a, input [31:0] e);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task hit(input [5:0] i, input g);
        @(posedge clk);
        {req, pidx} <= {1'b1, i};
        @(posedge clk);
        req <= 1'b0;
        #1 chk(grant, g);
        @(posedge clk);
        #1 chk(perr, !g);
    endtask
    task t_reset;
        rdr(8'h00, 32'h2);
        rdr(8'h04, 32'h2);
        rdr(8'h10, 32'h00800000);
    endtask
    task t_group1;
        wrr(8'h04, 32'h8, 4'h0, 1'b0);
        wrr(8'h04, 32'h0, 4'hf, 1'b0);
        rdr(8'h00, 32'h2);
        wrr(8'h00, 32'h2, 4'h1, 1'b0);
        rdr(8'h04, 32'h0);
        wrr(8'h04, 32'he, 4'h1, 1'b0);
        rdr(8'h00, 32'he);
        wrr(8'h04, 32'h8, 4'h1, 1'b1);
        wrr(8'h00, 32'h4, 4'h1, 1'b0);
        wrr(8'h00, 32'h4, 4'h1, 1'b1);
        wrr(8'h30, 32'h1, 4'h1, 1'b1);
        rdr(8'h30, 32'h0);
    endtask
    task t_guard;
        hit(6'h01, 1'b0);
        hit(6'h03, 1'b0);
        hit(6'h02, 1'b1);
        hit(6'h28, 1'b1);
        hit(6'h27, 1'b1);
        wrr(8'h10, 32'h100, 4'h2, 1'b1);
        wrr(8'h10, 32'h80, 4'h1, 1'b1);
        chk(g2, 32'h0);
    endtask
    task t_errors;
        rdr(8'h20, 32'h7);
        rdr(8'h24, 32'h00001000);
        rdr(8'h28, 32'h8);
        wrr(8'h20, 32'h3, 4'h1, 1'b0);
        rdr(8'h20, 32'h4);
        wrr(8'h28, 32'h0, 4'hf, 1'b0);
        rdr(8'h28, 32'h0);
        hit(6'h01, 1'b0);
        rdr(8'h24, 32'h00010001);
        chk(g1, 32'ha);
    endtask
    task t_restart;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1 chk(g1, 32'h2);
        rdr(8'h20, 32'h0);
        rdr(8'h28, 32'h0);
        rdr(8'h10, 32'h00800000);
        rdr(8'h04, 32'h2);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000 errors = errors + 1;
        test_done;
    end
    initial begin
        {arst_n, wr, rd, req, addr, wdata, be, pidx} = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_group1;
        t_guard;
        t_errors;
        t_restart;
        test_done;
    end
endmodule
bind pwpg_top pwpg_top_sva #(.CNT_W(CNT_W)) chk_u (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_BE_I(REG_BE_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .REG_ERR_O(REG_ERR_O), .PERIPH_WR_I(PERIPH_WR_I),
    .PERIPH_IDX_I(PERIPH_IDX_I), .PERIPH_GRANT_O(PERIPH_GRANT_O), .PERIPH_ERR_O(PERIPH_ERR_O),
    .GRP1_LOCK_O(GRP1_LOCK_O), .GRP2_LOCK_O(GRP2_LOCK_O));

// >>> verilog/pwpg_group.v
`timescale 1ns/10ps
module pwpg_group #(
    parameter [31:0] RESET_VAL = 32'h00000000,
    parameter [31:0] IMPL_MASK = 32'h00000000
) (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // Write requests, data already gated by byte lanes
    input wire clr_wr_i,
    input wire set_wr_i,
    input wire [31:0] wbits_i,
    // State
    output wire [31:0] lock_o,
    output wire [31:0] rd_val_o,
    output wire repeat_o
);
    reg [31:0] lock_q;
    reg [31:0] lock_d;
    wire [31:0] hit;

    assign hit = wbits_i & IMPL_MASK;

    always @* begin
        lock_d = lock_q;
        if (clr_wr_i) begin
            lock_d = lock_q & ~hit;
        end else if (set_wr_i) begin
            lock_d = lock_q | hit;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_q <= RESET_VAL & IMPL_MASK;
        end else begin
            lock_q <= lock_d;
        end
    end

    // A one written to a bit already in the requested state is a repeat
    assign repeat_o = (set_wr_i && ((hit & lock_q) != 32'h00000000)) ||
                      (clr_wr_i && ((hit & ~lock_q) != 32'h00000000));

    assign lock_o = lock_q;
    // Unused bits read back their reset value; 1 means locked
    assign rd_val_o = lock_q | (RESET_VAL & ~IMPL_MASK);
endmodule

// >>> verilog/pwpg_top.v
// Operation
// - Group-one clear at 0x00, reset 0x000002
// - Group-one set at 0x04, same state
// - Group one: port, memory, debug bits
// - Group two: touch, converters, comparators, events
// - Group two bits 15:8 guard timers
// - Group two bits 7:2 guard serial units
// - Writing zero to a guard register changes nothing
// - Clear bit unlocks; read one means locked, except unused group-two bit 23, which reads one and never locks
// - Locked peripheral write discarded, bus error
// - Repeated lock or unlock gives error
`timescale 1ns/10ps
`include "pwpg_map.vh"
module pwpg_top #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire CLK_SYS_I,
    input wire ARST_N_I,
    // Register port
    input wire [7:0] REG_ADDR_I,
    input wire [31:0] REG_WDATA_I,
    input wire [3:0] REG_BE_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    output wire [31:0] REG_RDATA_O,
    output wire REG_ERR_O,
    // Peripheral write guard
    input wire PERIPH_WR_I,
    input wire [5:0] PERIPH_IDX_I,
    output wire PERIPH_GRANT_O,
    output wire PERIPH_ERR_O,
    // Lock state towards the peripherals
    output wire [31:0] GRP1_LOCK_O,
    output wire [31:0] GRP2_LOCK_O
);
    localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // Expand byte enables to a bit mask so sub-word writes to guard and status registers touch only their lanes; a counter write zeroes all bits
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    // Run of ones from lsb up to msb, used to build each group's guard mask
    function [31:0] bit_span;
        input integer msb;
        input integer lsb;
        integer k;
        begin
            bit_span = 32'h00000000;
            for (k = lsb; k <= msb; k = k + 1) begin
                bit_span[k] = 1'b1;
            end
        end
    endfunction

    // Lock bit of the guard a peripheral index names; bit 5 picks the group
    function guard_bit;
        input [5:0] idx;
        input [31:0] grp1;
        input [31:0] grp2;
        begin
            guard_bit = idx[5] ? grp2[idx[4:0]] : grp1[idx[4:0]];
        end
    endfunction

    // Guard fields; any bit outside them reads back its reset value and never locks
    localparam [31:0] G1_PORT = bit_span(`PWPG_G1_PORT_BIT, `PWPG_G1_PORT_BIT);
    localparam [31:0] G1_NVM = bit_span(`PWPG_G1_NVM_BIT, `PWPG_G1_NVM_BIT);
    localparam [31:0] G1_DBG = bit_span(`PWPG_G1_DBG_BIT, `PWPG_G1_DBG_BIT);
    localparam [31:0] G1_GUARDS = G1_PORT | G1_NVM | G1_DBG;
    localparam [31:0] G2_TOUCH = bit_span(`PWPG_G2_TOUCH_BIT, `PWPG_G2_TOUCH_BIT);
    localparam [31:0] G2_DAC = bit_span(`PWPG_G2_DAC_BIT, `PWPG_G2_DAC_BIT);
    localparam [31:0] G2_CMP = bit_span(`PWPG_G2_CMP_BIT, `PWPG_G2_CMP_BIT);
    localparam [31:0] G2_ADC = bit_span(`PWPG_G2_ADC_BIT, `PWPG_G2_ADC_BIT);
    localparam [31:0] G2_TIMERS = bit_span(`PWPG_G2_TIMER_MSB, `PWPG_G2_TIMER_LSB);
    localparam [31:0] G2_SERIAL = bit_span(`PWPG_G2_SERIAL_MSB, `PWPG_G2_SERIAL_LSB);
    localparam [31:0] G2_EVENT = bit_span(`PWPG_G2_EVENT_BIT, `PWPG_G2_EVENT_BIT);
    localparam [31:0] G2_GUARDS = G2_TOUCH | G2_DAC | G2_CMP | G2_ADC | G2_TIMERS | G2_SERIAL | G2_EVENT;

    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg reg_err_q;
    reg periph_err_q;
    reg [31:0] err_stat_q;
    reg [31:0] err_stat_d;
    reg [31:0] err_info_q;
    reg [31:0] err_info_d;
    reg [CNT_W-1:0] err_cnt_q;
    reg [CNT_W-1:0] err_cnt_d;

    wire [31:0] wbits;
    wire sel_g1_clr;
    wire sel_g1_set;
    wire sel_g2_clr;
    wire sel_stat;
    wire sel_info;
    wire sel_cnt;
    wire sel_any;
    wire wr_g1_clr;
    wire wr_g1_set;
    wire wr_g2_clr;
    wire [31:0] g1_lock;
    wire [31:0] g2_lock;
    wire [31:0] g1_rd;
    wire [31:0] g2_rd;
    wire g1_repeat;
    wire g2_repeat;
    wire unmapped;
    wire repeat_err;
    wire periph_locked;
    wire periph_block;
    wire err_event;

    // Sub-word accesses to guard and status registers only ever move the lanes they enable
    assign wbits = REG_WDATA_I & lane_mask(REG_BE_I);

    assign sel_g1_clr = addr_hit(REG_ADDR_I, `PWPG_G1_CLR_OFS);
    assign sel_g1_set = addr_hit(REG_ADDR_I, `PWPG_G1_SET_OFS);
    assign sel_g2_clr = addr_hit(REG_ADDR_I, `PWPG_G2_CLR_OFS);
    assign sel_stat = addr_hit(REG_ADDR_I, `PWPG_ERR_STAT_OFS);
    assign sel_info = addr_hit(REG_ADDR_I, `PWPG_ERR_INFO_OFS);
    assign sel_cnt = addr_hit(REG_ADDR_I, `PWPG_ERR_CNT_OFS);
    assign sel_any = sel_g1_clr | sel_g1_set | sel_g2_clr | sel_stat | sel_info | sel_cnt;

    assign wr_g1_clr = REG_WR_I & sel_g1_clr;
    assign wr_g1_set = REG_WR_I & sel_g1_set;
    assign wr_g2_clr = REG_WR_I & sel_g2_clr;

    // Group one: port, memory controller and debug guards
    pwpg_group #(
        .RESET_VAL(`PWPG_G1_RESET),
        .IMPL_MASK(G1_GUARDS)
    ) u_grp1 (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .clr_wr_i(wr_g1_clr),
        .set_wr_i(wr_g1_set),
        .wbits_i(wbits),
        .lock_o(g1_lock),
        .rd_val_o(g1_rd),
        .repeat_o(g1_repeat)
    );

    // Group two: touch, converters, comparators, timers, serial units, events
    pwpg_group #(
        .RESET_VAL(`PWPG_G2_RESET),
        .IMPL_MASK(G2_GUARDS)
    ) u_grp2 (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .clr_wr_i(wr_g2_clr),
        .set_wr_i(1'b0),
        .wbits_i(wbits),
        .lock_o(g2_lock),
        .rd_val_o(g2_rd),
        .repeat_o(g2_repeat)
    );

    assign GRP1_LOCK_O = g1_lock;
    assign GRP2_LOCK_O = g2_lock;

    assign unmapped = (REG_WR_I | REG_RD_I) & ~sel_any;
    assign repeat_err = g1_repeat | g2_repeat;
    // One cycle can raise several errors; the counter still moves by one
    assign err_event = periph_block | repeat_err | unmapped;

    // Peripheral guard: index bit 5 picks the group, low bits the guard bit
    assign periph_locked = guard_bit(PERIPH_IDX_I, g1_lock, g2_lock);
    assign periph_block = PERIPH_WR_I & periph_locked;
    // Grant is combinational so the write is stopped in the same cycle
    assign PERIPH_GRANT_O = PERIPH_WR_I & ~periph_locked;

    // Read mux
    always @* begin
        rdata_d = 32'h00000000;
        if (REG_RD_I) begin
            if (sel_g1_clr || sel_g1_set) begin
                rdata_d = g1_rd;
            end else if (sel_g2_clr) begin
                rdata_d = g2_rd;
            end else if (sel_stat) begin
                rdata_d = err_stat_q;
            end else if (sel_info) begin
                rdata_d = err_info_q;
            end else if (sel_cnt) begin
                rdata_d = {{(32-CNT_W){1'b0}}, err_cnt_q};
            end
        end
    end

    // Error status: sticky, write one to clear, a new event wins over the clear
    always @* begin
        err_stat_d = err_stat_q;
        if (REG_WR_I && sel_stat) begin
            err_stat_d = err_stat_q & ~wbits;
        end
        if (repeat_err) begin
            err_stat_d[`PWPG_ERR_REPEAT_BIT] = 1'b1;
        end
        if (periph_block) begin
            err_stat_d[`PWPG_ERR_LOCKED_BIT] = 1'b1;
        end
        if (unmapped) begin
            err_stat_d[`PWPG_ERR_UNMAP_BIT] = 1'b1;
        end
        err_stat_d[31:3] = 29'h0;
    end

    // Error info: the peripheral error takes priority since it blocks data
    always @* begin
        err_info_d = err_info_q;
        if (periph_block) begin
            err_info_d = 32'h00000000;
            err_info_d[`PWPG_INFO_IDX_LSB+5:`PWPG_INFO_IDX_LSB] = PERIPH_IDX_I;
            err_info_d[`PWPG_INFO_SRC_BIT] = 1'b1;
        end else if (repeat_err || unmapped) begin
            err_info_d = 32'h00000000;
            err_info_d[`PWPG_INFO_ADDR_LSB+7:`PWPG_INFO_ADDR_LSB] = REG_ADDR_I;
        end
    end

    // Saturating counter of all error events; a write zeroes it, but an event in that cycle still counts one
    always @* begin
        err_cnt_d = err_cnt_q;
        if (REG_WR_I && sel_cnt) begin
            err_cnt_d = {CNT_W{1'b0}};
        end
        if (err_event && (err_cnt_d != CNT_MAX)) begin
            err_cnt_d = err_cnt_d + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read data stand one cycle only, then drop back to zero
    always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Register bus error answers the offending access in the next cycle
    always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            reg_err_q <= 1'b0;
        end else begin
            reg_err_q <= repeat_err | unmapped;
        end
    end

    // A refused peripheral write is flagged once, one cycle after the attempt
    always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            periph_err_q <= 1'b0;
        end else begin
            periph_err_q <= periph_block;
        end
    end

    // Sticky until software writes ones, so no error is lost between polls
    always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            err_stat_q <= `PWPG_ERR_RESET;
        end else begin
            err_stat_q <= err_stat_d;
        end
    end

    always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            err_info_q <= `PWPG_ERR_RESET;
        end else begin
            err_info_q <= err_info_d;
        end
    end

    // Saturates instead of wrapping so a flood of errors never reads as few
    always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            err_cnt_q <= {CNT_W{1'b0}};
        end else begin
            err_cnt_q <= err_cnt_d;
        end
    end

    assign REG_RDATA_O = rdata_q;
    assign REG_ERR_O = reg_err_q;
    assign PERIPH_ERR_O = periph_err_q;
endmodule
